// file: rtl/float_test_pkg.sv
package float_test_pkg;
    // opcode 170500 (octal) with the specifier field masked off
    localparam logic [15:0] OPCODE_MASK = 16'hFFC0;
    localparam logic [15:0] OPCODE_MATCH = 16'hF140;
    localparam int SPEC_W = 6;
    localparam int OPERAND_W = 64;
    // sign and exponent sit in the first word in both precisions
    localparam int SIGN_POS = 63;
    localparam int EXP_HI = 62;
    localparam int EXP_LO = 55;
    localparam int EXP_W = 8;
    localparam logic [EXP_W-1:0] EXP_ZERO = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [SPEC_W-1:0] SPEC_RESET = 6'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC = 2'b10
    } test_state_t;
endpackage

// file: rtl/float_operand_classify.sv
module float_operand_classify (
    // operand in memory word order, first word in the top bits
    input wire logic [float_test_pkg::OPERAND_W-1:0] operand,
    // classification
    output logic is_zero,
    output logic is_negative,
    output logic is_minus_zero
);
    logic sign;
    logic [float_test_pkg::EXP_W-1:0] exponent;

    always_comb begin
        sign = operand[float_test_pkg::SIGN_POS];
        exponent = operand[float_test_pkg::EXP_HI:float_test_pkg::EXP_LO];
        // a zero exponent means zero whatever the fraction holds
        is_zero = (exponent == float_test_pkg::EXP_ZERO);
        is_negative = sign && (exponent != float_test_pkg::EXP_ZERO);
        is_minus_zero = sign && (exponent == float_test_pkg::EXP_ZERO);
    end
endmodule

// file: rtl/float_test_condition_codes.sv
module float_test_condition_codes (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // instruction from the decoder
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic double_mode,
    // floating status control
    input wire logic undefined_variable_trap_enable,
    // operand fetch
    output logic operand_req,
    output logic [float_test_pkg::SPEC_W-1:0] float_destination_operand,
    output logic operand_double,
    input wire logic operand_valid,
    input wire logic [float_test_pkg::OPERAND_W-1:0] operand_data,
    // condition flags
    output logic float_carry_flag,
    output logic float_overflow_flag,
    output logic float_zero_flag,
    output logic float_negative_flag,
    // events and status
    output logic cc_update,
    output logic float_trap,
    output logic overflow_trap,
    output logic underflow_trap,
    output logic done,
    output logic busy
);
    float_test_pkg::test_state_t state;
    float_test_pkg::test_state_t next_state;
    logic next_operand_req;
    logic [float_test_pkg::SPEC_W-1:0] next_spec;
    logic next_operand_double;
    logic next_carry;
    logic next_overflow;
    logic next_zero;
    logic next_negative;
    logic next_cc_update;
    logic next_float_trap;
    logic next_done;
    logic next_busy;
    logic zero_seen;
    logic next_zero_seen;
    logic negative_seen;
    logic next_negative_seen;
    logic is_zero;
    logic is_negative;
    logic is_minus_zero;
    logic instr_match;

    float_operand_classify u_classify (
        .operand(operand_data),
        .is_zero(is_zero),
        .is_negative(is_negative),
        .is_minus_zero(is_minus_zero)
    );

    assign instr_match = ((instr_word & float_test_pkg::OPCODE_MASK)
                          == float_test_pkg::OPCODE_MATCH);

    always_comb begin
        next_state = state;
        next_operand_req = operand_req;
        next_spec = float_destination_operand;
        next_operand_double = operand_double;
        next_carry = float_carry_flag;
        next_overflow = float_overflow_flag;
        next_zero = float_zero_flag;
        next_negative = float_negative_flag;
        next_cc_update = 1'b0;
        next_float_trap = 1'b0;
        next_done = 1'b0;
        next_zero_seen = zero_seen;
        next_negative_seen = negative_seen;
        unique case (state)
            float_test_pkg::ST_IDLE: begin
                // other opcodes belong to other units and are ignored
                if (instr_valid && instr_match) begin
                    next_spec =
                        instr_word[float_test_pkg::SPEC_W-1:0];
                    next_operand_double = double_mode;
                    next_operand_req = 1'b1;
                    next_state = float_test_pkg::ST_FETCH;
                end
            end
            float_test_pkg::ST_FETCH: begin
                if (operand_valid) begin
                    next_operand_req = 1'b0;
                    // the check comes first so a trapped test touches no flag
                    if (undefined_variable_trap_enable && is_minus_zero) begin
                        next_float_trap = 1'b1;
                        next_state = float_test_pkg::ST_IDLE;
                    end else begin
                        next_zero_seen = is_zero;
                        next_negative_seen = is_negative;
                        next_state = float_test_pkg::ST_EXEC;
                    end
                end
            end
            float_test_pkg::ST_EXEC: begin
                next_carry = 1'b0;
                next_overflow = 1'b0;
                next_zero = zero_seen;
                next_negative = negative_seen;
                next_cc_update = 1'b1;
                next_done = 1'b1;
                next_state = float_test_pkg::ST_IDLE;
            end
            default: begin
                next_operand_req = 1'b0;
                next_state = float_test_pkg::ST_IDLE;
            end
        endcase
        next_busy = (next_state != float_test_pkg::ST_IDLE);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= float_test_pkg::ST_IDLE;
            operand_req <= 1'b0;
            float_destination_operand <= float_test_pkg::SPEC_RESET;
            operand_double <= 1'b0;
            float_carry_flag <= float_test_pkg::FLAG_RESET;
            float_overflow_flag <= float_test_pkg::FLAG_RESET;
            float_zero_flag <= float_test_pkg::FLAG_RESET;
            float_negative_flag <= float_test_pkg::FLAG_RESET;
            cc_update <= 1'b0;
            float_trap <= 1'b0;
            done <= 1'b0;
            busy <= 1'b0;
            zero_seen <= 1'b0;
            negative_seen <= 1'b0;
        end else begin
            state <= next_state;
            operand_req <= next_operand_req;
            float_destination_operand <= next_spec;
            operand_double <= next_operand_double;
            float_carry_flag <= next_carry;
            float_overflow_flag <= next_overflow;
            float_zero_flag <= next_zero;
            float_negative_flag <= next_negative;
            cc_update <= next_cc_update;
            float_trap <= next_float_trap;
            done <= next_done;
            busy <= next_busy;
            zero_seen <= next_zero_seen;
            negative_seen <= next_negative_seen;
        end
    end

    // no arithmetic is done, so these traps stay quiet by construction
    always_ff @(posedge clock) begin
        overflow_trap <= 1'b0;
        underflow_trap <= 1'b0;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic mz_trap_case;
    logic test_case;
    assign mz_trap_case = (state == float_test_pkg::ST_FETCH) && operand_valid
                          && undefined_variable_trap_enable && is_minus_zero;
    assign test_case = (state == float_test_pkg::ST_FETCH) && operand_valid
                       && !(undefined_variable_trap_enable && is_minus_zero);

    property p_decode;
        (state == float_test_pkg::ST_IDLE) && instr_valid && instr_match
            |=> operand_req && busy
                && float_destination_operand == $past(instr_word[5:0]);
    endproperty
    a_decode: assert property (p_decode)
        else $error("matching opcode not taken");

    property p_ignore;
        (state == float_test_pkg::ST_IDLE) && !(instr_valid && instr_match)
            |=> !busy && !operand_req;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("non matching opcode started a test");

    property p_clear_cv;
        cc_update |-> !float_carry_flag && !float_overflow_flag;
    endproperty
    a_clear_cv: assert property (p_clear_cv)
        else $error("carry or overflow flag left set by test");

    property p_zero;
        test_case |-> ##2 cc_update && float_zero_flag == $past(is_zero, 2);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong after test");

    property p_negative;
        test_case |-> ##2 cc_update
            && float_negative_flag == $past(is_negative, 2);
    endproperty
    a_negative: assert property (p_negative)
        else $error("negative flag wrong after test");

    property p_trap;
        mz_trap_case |=> float_trap && !cc_update && !done
            && $stable(float_zero_flag) && $stable(float_negative_flag)
            ##1 !cc_update && !busy;
    endproperty
    a_trap: assert property (p_trap)
        else $error("minus zero trap missing or flags changed");

    property p_no_trap_otherwise;
        float_trap |-> $past(mz_trap_case);
    endproperty
    a_no_trap_otherwise: assert property (p_no_trap_otherwise)
        else $error("spurious floating trap");

    property p_no_ovf;
        ##1 (!overflow_trap && !underflow_trap);
    endproperty
    a_no_ovf: assert property (p_no_ovf)
        else $error("overflow or underflow trap raised by test");

    property p_flags_hold;
        !cc_update |-> $stable(float_zero_flag)
            && $stable(float_negative_flag);
    endproperty
    a_flags_hold: assert property (p_flags_hold)
        else $error("flags changed without an update");

    c_zero: cover property (cc_update && float_zero_flag);
    c_negative: cover property (cc_update && float_negative_flag);
    c_trap: cover property (float_trap);
    c_positive: cover property (cc_update && !float_zero_flag
                                && !float_negative_flag);
endmodule

// file: verification/float_operand_source.sv
module float_operand_source (
    // clock
    input wire logic clock,
    // fetch request from the block
    input wire logic operand_req,
    // behaviour chosen by the bench
    input wire logic [3:0] wait_cycles,
    input wire logic [63:0] value,
    // answer
    output logic operand_valid,
    output logic [63:0] operand_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    logic served = 1'b0;
    initial begin
        operand_valid = 1'b0;
        operand_data = 64'h0;
    end
    // released data bus shows the inverse of the last word, not a held copy
    always @(negedge clock) begin
        if (operand_valid) begin
            operand_valid <= 1'b0;
            served <= 1'b1;
            operand_data <= ~operand_data;
        end else if (!operand_req) begin
            served <= 1'b0;
            cnt <= 0;
        end else if (!served) begin
            if (cnt >= int'(wait_cycles)) begin
                operand_valid <= 1'b1;
                operand_data <= value;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

// file: verification/float_test_condition_codes_test.sv
`define CHECK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    error_cnt++; $display("Error at %0t: mismatch on line %0d", \
    $time, `__LINE__); end end
module float_test_condition_codes_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic double_mode = 1'b0;
    logic trap_en = 1'b0;
    logic operand_req, operand_double, operand_valid;
    logic [5:0] spec;
    logic [63:0] operand_data;
    logic [63:0] value = 64'h0;
    logic [3:0] wait_cycles = 4'h0;
    logic fc, fv, fz, fn, cc_update, float_trap, ov_trap, un_trap;
    logic done, busy;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    always #25 clock = ~clock;

    float_test_condition_codes dut (.clock(clock), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .double_mode(double_mode),
        .undefined_variable_trap_enable(trap_en),
        .operand_req(operand_req), .float_destination_operand(spec),
        .operand_double(operand_double), .operand_valid(operand_valid),
        .operand_data(operand_data), .float_carry_flag(fc),
        .float_overflow_flag(fv), .float_zero_flag(fz),
        .float_negative_flag(fn), .cc_update(cc_update),
        .float_trap(float_trap), .overflow_trap(ov_trap),
        .underflow_trap(un_trap), .done(done), .busy(busy));

    float_operand_source far_side (.clock(clock), .operand_req(operand_req),
        .wait_cycles(wait_cycles), .value(value),
        .operand_valid(operand_valid), .operand_data(operand_data));

    task automatic test_done();
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // run one test instruction and judge its outcome
    task automatic run_op(input logic [5:0] sp, input logic dbl,
                          input logic en_trap, input logic [63:0] v,
                          input logic [3:0] dly, input logic ez,
                          input logic en, input logic tr);
        logic z0, n0;
        int i;
        z0 = fz;
        n0 = fn;
        instr_word = float_test_pkg::OPCODE_MATCH | {10'h000, sp};
        instr_valid = 1'b1;
        double_mode = dbl;
        trap_en = en_trap;
        value = v;
        wait_cycles = dly;
        @(negedge clock);
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        `CHECK(operand_req, 1'b1)
        `CHECK(spec, sp)
        `CHECK(operand_double, dbl)
        for (i = 0; i < 20 && done !== 1'b1 && float_trap !== 1'b1; i++)
            @(negedge clock);
        `CHECK(float_trap, tr)
        `CHECK(done, ~tr)
        `CHECK(cc_update, ~tr)
        `CHECK(fz, tr ? z0 : ez)
        `CHECK(fn, tr ? n0 : en)
        `CHECK(fc, 1'b0)
        `CHECK(fv, 1'b0)
        `CHECK(ov_trap, 1'b0)
        `CHECK(un_trap, 1'b0)
        `CHECK(busy, 1'b0)
        @(negedge clock);
    endtask

    // a word one bit off the opcode must be ignored
    task automatic refuse_foreign();
        instr_word = float_test_pkg::OPCODE_MATCH ^ 16'h0040;
        instr_valid = 1'b1;
        repeat (3) @(negedge clock);
        instr_valid = 1'b0;
        `CHECK(busy, 1'b0)
        `CHECK(operand_req, 1'b0)
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles >= 2000) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        `CHECK(fz, 1'b0)
        run_op(6'h25, 1'b0, 1'b0, 64'h4080_0000_FFFF_FFFF, 4'h0,
               1'b0, 1'b0, 1'b0);
        run_op(6'h3F, 1'b1, 1'b1, 64'hC123_4567_89AB_CDEF, 4'h3,
               1'b0, 1'b1, 1'b0);
        run_op(6'h00, 1'b1, 1'b1, 64'h8000_0000_0000_0000, 4'h2,
               1'b0, 1'b1, 1'b1);
        run_op(6'h11, 1'b0, 1'b0, 64'h8000_0000_0000_0000, 4'h1,
               1'b1, 1'b0, 1'b0);
        run_op(6'h2A, 1'b0, 1'b1, 64'h8080_0000_0000_0000, 4'h0,
               1'b0, 1'b1, 1'b0);
        run_op(6'h07, 1'b1, 1'b1, 64'h007F_FFFF_FFFF_FFFF, 4'h5,
               1'b1, 1'b0, 1'b0);
        refuse_foreign();
        test_done();
    end
endmodule
